// File: src/led_i2c_dev_end.sv
// Purpose: serial slave front end of the seven-output LED driver
// Assumes: link wires arrive asynchronously; rd_data is on hclk
// Notes: register contents live outside; writes leave as strobes
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module led_i2c_dev_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic en,
    i2c_link_if.device link,
    output logic wr_stb,
    output logic [led_i2c_pkg::SEL_W-1:0] wr_sel,
    output logic [led_i2c_pkg::BYTE_W-1:0] wr_data,
    output logic [led_i2c_pkg::SEL_W-1:0] rd_sel,
    input wire logic [led_i2c_pkg::BYTE_W-1:0] rd_data,
    output logic shutdown
);
    import led_i2c_pkg::*;

    // ==========================================
    // Input synchronisers
    logic scl_s1_r, scl_s2_r, scl_s3_r;
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic en_s1_r, en_s2_r;
    logic scl_s1_nxt, sda_s1_nxt, en_s1_nxt;

    always_comb begin
        scl_s1_nxt = link.scl;
        sda_s1_nxt = link.sda;
        en_s1_nxt = en;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else if (ce) begin
            scl_s1_r <= scl_s1_nxt;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_s1_nxt;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            en_s1_r <= en_s1_nxt;
            en_s2_r <= en_s1_r;
        end
    end

    // ==========================================
    // Line events
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_rise = scl_s2_r & ~scl_s3_r;
        scl_fall = ~scl_s2_r & scl_s3_r;
        // Data edge while clock stays high is a condition, not a bit
        start_det = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
        stop_det = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;
    end

    // ==========================================
    // Protocol state machine
    dev_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic rw_r, rw_nxt;
    logic sda_oen_r, sda_oen_nxt;
    logic wr_stb_r, wr_stb_nxt;
    logic [3:0] wr_sel_r, wr_sel_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic shutdown_r, shutdown_nxt;
    logic byte_done;

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        rw_nxt = rw_r;
        sda_oen_nxt = sda_oen_r;
        wr_stb_nxt = 1'b0;
        wr_sel_nxt = wr_sel_r;
        wr_data_nxt = wr_data_r;
        shutdown_nxt = ~en_s2_r;
        byte_done = (bit_cnt_r == BITS_PER_BYTE);
        if (!en_s2_r) begin
            // Shutdown holds protocol state and command at default; wr_sel and wr_data keep their value
            state_nxt = S_IDLE;
            bit_cnt_nxt = 4'h0;
            shift_nxt = 8'h00;
            cmd_nxt = CMD_RESET;
            rw_nxt = 1'b0;
            sda_oen_nxt = 1'b1;
        end else if (stop_det) begin
            state_nxt = S_IDLE;
            sda_oen_nxt = 1'b1;
        end else if (start_det) begin
            state_nxt = S_ADDR;
            bit_cnt_nxt = 4'h0;
            sda_oen_nxt = 1'b1;
        end else begin
            unique case (state_r)
                S_IDLE, S_WAIT: begin
                end
                S_ADDR, S_CMD, S_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        // MSB arrives first
                        shift_nxt = {shift_r[6:0], sda_s2_r};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_nxt = 4'h0;
                        if (state_r == S_ADDR) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_nxt = shift_r[0];
                                sda_oen_nxt = 1'b0;
                                state_nxt = S_ADDR_ACK;
                            end else begin
                                state_nxt = S_WAIT;
                            end
                        end else if (state_r == S_CMD) begin
                            if (shift_r[3:0] <= SEL_LAST_VALID) begin
                                cmd_nxt = shift_r;
                                sda_oen_nxt = 1'b0;
                                state_nxt = S_CMD_ACK;
                            end else begin
                                // Reserved selection: no ack, old command kept
                                state_nxt = S_WAIT;
                            end
                        end else begin
                            sda_oen_nxt = 1'b0;
                            state_nxt = S_WDATA_ACK;
                            wr_stb_nxt = 1'b1;
                            wr_sel_nxt = cmd_r[3:0];
                            wr_data_nxt = shift_r;
                            if (cmd_r[3:0] == SEL_INIT) begin
                                cmd_nxt = CMD_RESET;
                            end else if (cmd_r[CMD_AI_BIT]) begin
                                cmd_nxt[3:0] = cmd_r[3:0] + 4'h1;
                            end
                        end
                    end
                end
                S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK: begin
                    if (scl_fall) begin
                        // Ack ends on the falling edge, line freed at once unless a read drives its first data bit
                        sda_oen_nxt = 1'b1;
                        if (state_r == S_ADDR_ACK && rw_r) begin
                            // Reads skip the command byte entirely
                            shift_nxt = rd_data;
                            sda_oen_nxt = rd_data[7];
                            state_nxt = S_RDATA;
                        end else if (state_r == S_ADDR_ACK) begin
                            state_nxt = S_CMD;
                        end else begin
                            state_nxt = S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            // Free the line for the master's ack bit
                            sda_oen_nxt = 1'b1;
                            bit_cnt_nxt = 4'h0;
                            state_nxt = S_RACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            sda_oen_nxt = shift_r[6];
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        // NACK: stay off the line until the next start or stop
                        state_nxt = sda_s2_r ? S_WAIT : S_RLOAD;
                    end
                end
                S_RLOAD: begin
                    if (scl_fall) begin
                        shift_nxt = rd_data;
                        sda_oen_nxt = rd_data[7];
                        state_nxt = S_RDATA;
                    end
                end
                default: begin
                    state_nxt = S_IDLE;
                    sda_oen_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            cmd_r <= CMD_RESET;
            rw_r <= 1'b0;
            sda_oen_r <= 1'b1;
            wr_stb_r <= 1'b0;
            wr_sel_r <= 4'h0;
            wr_data_r <= 8'h00;
            shutdown_r <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            rw_r <= rw_nxt;
            sda_oen_r <= sda_oen_nxt;
            wr_stb_r <= wr_stb_nxt;
            wr_sel_r <= wr_sel_nxt;
            wr_data_r <= wr_data_nxt;
            shutdown_r <= shutdown_nxt;
        end
    end

    // ==========================================
    // Outputs
    // Open drain: only ever pulls low
    assign link.d_sda_o = 1'b0;
    assign link.d_sda_oen = sda_oen_r;
    assign wr_stb = wr_stb_r;
    assign wr_sel = wr_sel_r;
    assign wr_data = wr_data_r;
    assign rd_sel = cmd_r[3:0];
    assign shutdown = shutdown_r;
endmodule

// File: src/led_i2c_pkg.sv
// Purpose: shared constants and types of the LED driver serial front end
// Assumes: 125 MHz system clock
// Notes: master engine and device end both import this package
package led_i2c_pkg;
    // ==========================================
    // Widths and bus constants
    localparam int BYTE_W = 8;
    localparam int SEL_W = 4;
    localparam int AHB_DW = 32;
    localparam int AHB_AW = 32;
    localparam logic [6:0] DEV_ADDR = 7'h45;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ==========================================
    // Command byte layout
    localparam int CMD_AI_BIT = 4;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [3:0] SEL_INIT = 4'hA;
    localparam logic [3:0] SEL_LAST_VALID = 4'hA;
    // ==========================================
    // Link timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QUARTER_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] QUARTER_LAST = 7'(QUARTER_CYC - 1);
    // ==========================================
    // Controller registers
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam int CMD_TX_LSB = 0;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_READ_BIT = 9;
    localparam int CMD_NACK_BIT = 10;
    localparam int CMD_STOP_BIT = 11;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_RX_LSB = 8;
    localparam int HTRANS_ACTIVE_BIT = 1;
    // ==========================================
    // State types
    typedef enum logic [3:0] {
        S_IDLE, S_WAIT, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK, S_RLOAD
    } dev_state_t;
    typedef enum logic [1:0] {M_IDLE, M_START, M_BITS, M_STOP} mst_state_t;
endpackage

// File: src/i2c_link_if.sv
// Purpose: two-wire link between controller and LED driver front end
// Assumes: pull-ups on both wires
// Notes: enables are active low; wire level is resolved here
`timescale 1ns/1ps
interface i2c_link_if;
    logic m_scl_o;
    logic m_scl_oen;
    logic m_sda_o;
    logic m_sda_oen;
    logic d_sda_o;
    logic d_sda_oen;
    logic scl;
    logic sda;
    // ==========================================
    // Wired-AND with pull-up
    assign scl = ~(~m_scl_oen & ~m_scl_o);
    assign sda = ~((~m_sda_oen & ~m_sda_o) | (~d_sda_oen & ~d_sda_o));
    modport master (output m_scl_o, output m_scl_oen, output m_sda_o,
        output m_sda_oen, input scl, input sda);
    modport device (output d_sda_o, output d_sda_oen, input scl, input sda);
endinterface

// File: src/led_i2c_mst_end.sv
// Purpose: byte-level two-wire master driven from AHB-Lite registers
// Assumes: single slave, no clock stretching on the link
// Notes: one command register, one status register
`timescale 1ns/1ps
module led_i2c_mst_end (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [led_i2c_pkg::AHB_AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [led_i2c_pkg::AHB_DW-1:0] hwdata,
    input wire logic hready,
    output logic [led_i2c_pkg::AHB_DW-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    i2c_link_if.master link
);
    import led_i2c_pkg::*;

    // ==========================================
    // Bus slave
    logic ap_wr_r, ap_wr_nxt;
    logic [7:0] ap_addr_r, ap_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic [31:0] status;
    logic ap_valid, go;
    logic busy_r, nack_r;
    logic [7:0] rx_r;

    always_comb begin
        status = 32'h0000_0000;
        status[STAT_BUSY_BIT] = busy_r;
        status[STAT_NACK_BIT] = nack_r;
        status[STAT_RX_LSB +: 8] = rx_r;
        ap_valid = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
        ap_wr_nxt = ap_valid & hwrite;
        ap_addr_nxt = haddr[7:0];
        hrdata_nxt = 32'h0000_0000;
        if (ap_valid && !hwrite && haddr[7:0] == OFS_STATUS) begin
            hrdata_nxt = status;
        end
        // Commands written while busy are dropped
        go = ap_wr_r & (ap_addr_r == OFS_CMD) & ~busy_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r <= 1'b0;
            ap_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else if (ce) begin
            ap_wr_r <= ap_wr_nxt;
            ap_addr_r <= ap_addr_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // ==========================================
    // Bit engine
    mst_state_t st_r, st_nxt;
    logic [6:0] q_r, q_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] tx_r, tx_nxt, rx_nxt;
    logic rd_r, rd_nxt, mnack_r, mnack_nxt, stop_r, stop_nxt;
    logic nack_nxt, busy_nxt;
    logic scl_oen_r, scl_oen_nxt, sda_oen_r, sda_oen_nxt;
    logic sda_s1_r, sda_s2_r;
    logic tick, last_bit;

    always_comb begin
        st_nxt = st_r;
        q_nxt = q_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        rd_nxt = rd_r;
        mnack_nxt = mnack_r;
        stop_nxt = stop_r;
        nack_nxt = nack_r;
        busy_nxt = busy_r;
        scl_oen_nxt = scl_oen_r;
        sda_oen_nxt = sda_oen_r;
        tick = (st_r != M_IDLE) && (q_r == QUARTER_LAST);
        last_bit = (bit_r == BITS_PER_BYTE);
        if (st_r != M_IDLE) begin
            q_nxt = tick ? 7'h00 : q_r + 7'h01;
            ph_nxt = tick ? ph_r + 2'h1 : ph_r;
        end
        unique case (st_r)
            M_IDLE: begin
                if (go) begin
                    busy_nxt = 1'b1;
                    tx_nxt = hwdata[CMD_TX_LSB +: 8];
                    rd_nxt = hwdata[CMD_READ_BIT];
                    mnack_nxt = hwdata[CMD_NACK_BIT];
                    stop_nxt = hwdata[CMD_STOP_BIT];
                    st_nxt = hwdata[CMD_START_BIT] ? M_START : M_BITS;
                    ph_nxt = 2'h0;
                    bit_nxt = 4'h0;
                end
            end
            M_START: begin
                if (tick) begin
                    unique case (ph_r)
                        2'h0: sda_oen_nxt = 1'b1;
                        2'h1: scl_oen_nxt = 1'b1;
                        2'h2: sda_oen_nxt = 1'b0;
                        2'h3: begin
                            scl_oen_nxt = 1'b0;
                            st_nxt = M_BITS;
                        end
                    endcase
                end
            end
            M_BITS: begin
                if (tick) begin
                    unique case (ph_r)
                        2'h0: begin
                            // Data bit set a quarter period after the clock fall, with the clock still low
                            if (!last_bit) begin
                                sda_oen_nxt = rd_r | tx_r[7];
                            end else begin
                                sda_oen_nxt = rd_r ? mnack_r : 1'b1;
                            end
                        end
                        2'h1: scl_oen_nxt = 1'b1;
                        2'h2: begin
                            if (!last_bit) begin
                                rx_nxt = {rx_r[6:0], sda_s2_r};
                                tx_nxt = {tx_r[6:0], 1'b0};
                            end else if (!rd_r) begin
                                nack_nxt = sda_s2_r;
                            end
                        end
                        2'h3: begin
                            scl_oen_nxt = 1'b0;
                            bit_nxt = bit_r + 4'h1;
                            // Let go with the clock fall, before the far end may ack
                            if (bit_r == BITS_PER_BYTE - 4'h1) begin
                                sda_oen_nxt = 1'b1;
                            end
                            if (last_bit) begin
                                st_nxt = stop_r ? M_STOP : M_IDLE;
                                busy_nxt = stop_r;
                                sda_oen_nxt = stop_r ? sda_oen_r : 1'b1;
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (tick) begin
                    unique case (ph_r)
                        2'h0: sda_oen_nxt = 1'b0;
                        2'h1: scl_oen_nxt = 1'b1;
                        2'h2: sda_oen_nxt = 1'b1;
                        2'h3: begin
                            st_nxt = M_IDLE;
                            busy_nxt = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= M_IDLE;
            q_r <= 7'h00;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            rd_r <= 1'b0;
            mnack_r <= 1'b0;
            stop_r <= 1'b0;
            nack_r <= 1'b0;
            busy_r <= 1'b0;
            scl_oen_r <= 1'b1;
            sda_oen_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
            q_r <= q_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            rd_r <= rd_nxt;
            mnack_r <= mnack_nxt;
            stop_r <= stop_nxt;
            nack_r <= nack_nxt;
            busy_r <= busy_nxt;
            scl_oen_r <= scl_oen_nxt;
            sda_oen_r <= sda_oen_nxt;
            sda_s1_r <= link.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    // ==========================================
    // Outputs
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.m_scl_o = 1'b0;
    assign link.m_sda_o = 1'b0;
    assign link.m_scl_oen = scl_oen_r;
    assign link.m_sda_oen = sda_oen_r;
endmodule

// File: testbench/led_i2c_link_sva.sv
// Purpose: wire-level checks between the master end and the device end
// Assumes: one hclk domain, pull-ups on both wires
// Notes: sees only the link signals, never the user sides
`timescale 1ns/1ps
module led_i2c_link_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_scl_o,
    input wire logic m_sda_o,
    input wire logic d_sda_o,
    input wire logic m_sda_oen,
    input wire logic d_sda_oen
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================
    // Assertions
    property p_open_drain;
        (m_scl_o == 1'b0) && (m_sda_o == 1'b0) && (d_sda_o == 1'b0);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("link driven high");
    property p_dev_change_low;
        $changed(d_sda_oen) |-> !scl;
    endproperty
    a_dev_change_low: assert property (p_dev_change_low) else $error("device moved sda");
    property p_ack_held;
        ($rose(scl) && !d_sda_oen) |=> (!d_sda_oen) [*8];
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("device low not held");
    property p_one_talker;
        !d_sda_oen |-> m_sda_oen;
    endproperty
    a_one_talker: assert property (p_one_talker) else $error("both ends pull sda");
    property p_start_free;
        (scl && $fell(sda)) |-> (d_sda_oen && !m_sda_oen);
    endproperty
    a_start_free: assert property (p_start_free) else $error("bad start owner");
    property p_stop_idle;
        (scl && $rose(sda)) |=> d_sda_oen [*8];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("device busy after stop");
    property p_high_change;
        ($stable(scl) && scl && $changed(sda)) |-> ($changed(m_sda_oen) && d_sda_oen);
    endproperty
    a_high_change: assert property (p_high_change) else $error("sda moved in high");
    property p_scl_high;
        $rose(scl) |-> scl [*8];
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    c_start: cover property (scl && $fell(sda));
    c_ack: cover property ($rose(scl) && !d_sda_oen);
    c_stop: cover property (scl && $rose(sda));
endmodule

// File: testbench/led_driver_i2c_slave_front_bench.sv
// Purpose: drives the master end over AHB-Lite and watches the device end
// Assumes: zero-wait slave; en high except in the shutdown test
// Notes: rd_data follows rd_sel so read bytes are traceable
`timescale 1ns/1ps
module led_driver_i2c_slave_front_bench;
    import led_i2c_pkg::*;
    typedef struct packed {logic [7:0] cmd; logic [7:0] dat; logic [3:0] sel; logic nak;} row_t;
    logic hclk, hresetn, en, hsel, hwrite, wr_stb, shutdown, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [3:0] wr_sel, rd_sel;
    logic [7:0] wr_data, rd_data;
    int num_errors = 0;
    int comparisons = 0;
    int nstb = 0;
    int k;
    row_t rows [5] = '{'{8'h03, 8'h5A, 4'h3, 1'b0}, '{8'h09, 8'hC3, 4'h9, 1'b0},
        '{8'h0A, 8'h11, 4'h0, 1'b0}, '{8'h0B, 8'h00, 4'h0, 1'b1}, '{8'h0F, 8'h00, 4'h0, 1'b1}};
    i2c_link_if link();
    led_i2c_mst_end u_led_i2c_mst_end (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
    led_i2c_dev_end u_led_i2c_dev_end (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .en(en),
        .link(link), .wr_stb(wr_stb), .wr_sel(wr_sel), .wr_data(wr_data), .rd_sel(rd_sel),
        .rd_data(rd_data), .shutdown(shutdown));
    led_i2c_link_sva u_led_i2c_link_sva (.hclk(hclk), .hresetn(hresetn), .scl(link.scl),
        .sda(link.sda), .m_scl_o(link.m_scl_o), .m_sda_o(link.m_sda_o), .d_sda_o(link.d_sda_o),
        .m_sda_oen(link.m_sda_oen), .d_sda_oen(link.d_sda_oen));
    // ==========================================
    // Clock, register stand-in, watchdog
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        rd_data <= {4'h9, rd_sel};
        if (wr_stb === 1'b1) nstb <= nstb + 1;
    end
    initial begin
        repeat (95000) @(posedge hclk);
        num_errors++;
        wrap_up();
    end
    // ==========================================
    // Tasks
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        st = hrdata;
    endtask
    // Flags {stop, nack, read, start} above the byte
    task automatic xfer(input logic [11:0] c);
        int n;
        ahb(1'b1, 32'(OFS_CMD), {20'h0, c});
        repeat (2) @(posedge hclk);
        n = 0;
        do begin
            ahb(1'b0, 32'(OFS_STATUS), 32'h0);
            n++;
        end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
        // A transfer that never finishes is a failure, not a hang
        if (st[STAT_BUSY_BIT] !== 1'b0) begin
            num_errors++;
            wrap_up();
        end
        chk("hresp", 0, hresp);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge hclk);
        chk("rst shutdown", 1, shutdown);
        chk("rst oen", 2'h3, {link.d_sda_oen, link.m_scl_oen});
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        foreach (rows[i]) begin
            k = nstb;
            xfer(12'h18A);
            chk("addr nack", 0, st[STAT_NACK_BIT]);
            xfer({rows[i].nak, 3'h0, rows[i].cmd});
            chk("cmd nack", 32'(rows[i].nak), st[STAT_NACK_BIT]);
            if (!rows[i].nak) begin
                xfer({4'h8, rows[i].dat});
                chk("wr_sel", 32'(rows[i].cmd[3:0]), wr_sel);
                chk("wr_data", 32'(rows[i].dat), wr_data);
            end
            chk("rd_sel", 32'(rows[i].sel), rd_sel);
            chk("strobes", k + (rows[i].nak ? 0 : 1), nstb);
        end
        xfer(12'h18A);
        xfer(12'h012);
        for (int j = 0; j < 3; j++) begin
            xfer({(j == 2) ? 4'h8 : 4'h0, 8'h20 + 8'(j)});
            chk("ai wr_sel", 2 + j, wr_sel);
        end
        chk("ai rd_sel", 5, rd_sel);
        xfer(12'h18B);
        chk("rd addr nack", 0, st[STAT_NACK_BIT]);
        xfer(12'h200);
        chk("rd byte", 8'h95, st[15:8]);
        xfer(12'hE00);
        chk("rd last", 8'h95, st[15:8]);
        chk("rd keeps sel", 5, rd_sel);
        chk("released", 1, link.d_sda_oen);
        k = nstb;
        xfer(12'h18C);
        chk("foreign nack", 1, st[STAT_NACK_BIT]);
        xfer(12'h8FF);
        chk("foreign strobes", k, nstb);
        en <= 1'b0;
        repeat (8) @(posedge hclk);
        chk("shutdown", 1, shutdown);
        chk("sd rd_sel", 0, rd_sel);
        en <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("wake", 0, shutdown);
        wrap_up();
    end
endmodule
